// ### hw/wrwt_pkg.sv
// Constants and types shared by the watchdog reset and wakeup timer.
// Assumes a single 125 MHz bus clock; the watchdog clock arrives as a sampled input.
package wrwt_pkg;
    // Register map (byte addresses on the AXI4-Lite slave)
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_STAT      = 12'h004;
    localparam logic [11:0] OFS_MASK      = 12'h008;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0700;
    // Control field positions
    localparam int          BIT_CLR       = 0;
    localparam int          BIT_RST_EN    = 1;
    localparam int          BIT_RST_FLAG  = 2;
    localparam int          BIT_IRQ_FLAG  = 3;
    localparam int          BIT_WAKE_EN   = 4;
    localparam int          BIT_WAKE_FLAG = 5;
    localparam int          BIT_IRQ_EN    = 6;
    localparam int          BIT_EN        = 7;
    localparam int          SEL_LSB       = 8;
    localparam int          SEL_MSB       = 10;
    localparam logic [2:0]  SEL_RESET     = 3'h7;
    // Event status bits
    localparam int          EV_W          = 3;
    localparam int          EV_TIMEOUT    = 0;
    localparam int          EV_RESET      = 1;
    localparam int          EV_WAKE       = 2;
    // Counter and timing, in watchdog clock periods
    localparam int          CNT_W         = 18;
    localparam logic [4:0]  SHIFT_BASE    = 5'h04;
    localparam logic [10:0] GRACE_LAST    = 11'h3FF;
    localparam logic [5:0]  HOLD_LAST     = 6'h3E;
    // Unlock sequence
    localparam logic [7:0]  UNLOCK_B0     = 8'h59;
    localparam logic [7:0]  UNLOCK_B1     = 8'h16;
    localparam logic [7:0]  UNLOCK_B2     = 8'h88;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0]
    {
        WRWT_IDLE  = 2'h0,
        WRWT_COUNT = 2'h1,
        WRWT_GRACE = 2'h3,
        WRWT_HOLD  = 2'h2
    } wrwt_state_e;
endpackage

// ### hw/wrwt_watchdog.sv
// Watchdog timer with time-out interrupt, grace delay, CPU reset and power-down wakeup.
// Assumes all inputs are synchronous to aclk and watchdog_clock is slower than aclk / 2.
//
// Summary of operation
// - Setting the enable field starts the counter counting upward.
// - The counter is an 18-bit free-running up-counter stepped by the watchdog clock.
// - Interval code 000 means 2^4 clocks, each step times four, 111 means 2^18.
// - Reaching the interval sets the interrupt flag; interrupt asserts while enabled.
// - Every time-out starts a 1024 watchdog clock grace delay before action.
// - Writing one to clear zeroes the counter; the field then clears itself.
// - Writing zero to the clear field changes nothing.
// - Uncleared at grace end with reset enabled: set reset flag, assert CPU reset.
// - The CPU reset lasts 63 watchdog clock periods.
// - The reset flag survives the reset and clears only by writing one.
// - With reset disabled there is no reset and the reset flag stays put.
// - Powered down with wakeup enabled, an uncleared grace end wakes the chip.
// - A watchdog wakeup sets the wake flag; only writing one clears it.
// - Writing one clears the interrupt flag; writing zero leaves it.
// - Clearing the enable field zeroes the counter and stops the watchdog, except that a running CPU reset lasts its full length.
// - Protected fields take writes only after unlock bytes 59h, 16h, 88h.
// - Wakeup works only while the low-speed RC oscillator clocks the watchdog.
`timescale 1ns/1ps
module wrwt_watchdog
    import wrwt_pkg::*;
(
    // Clock and reset
    input  logic                        aclk,
    input  logic                        aresetn,
    // AXI4-Lite write
    input  logic [wrwt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  logic                        s_axi_awvalid,
    output logic                        s_axi_awready,
    input  logic [31:0]                 s_axi_wdata,
    input  logic [3:0]                  s_axi_wstrb,
    input  logic                        s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  logic                        s_axi_bready,
    // AXI4-Lite read
    input  logic [wrwt_pkg::ADDR_W-1:0] s_axi_araddr,
    input  logic                        s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  logic                        s_axi_rready,
    // Watchdog clock and chip state
    input  logic                        watchdog_clock,
    input  logic                        low_speed_rc_clock_sel,
    input  logic                        power_down,
    // Unlock port
    input  logic                        register_unlock_port_wr,
    input  logic [7:0]                  register_unlock_port_data,
    // Outputs to the system
    output logic                        irq,
    output logic                        cpu_reset,
    output logic                        chip_wakeup
);
    import wrwt_pkg::*;

    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wr_fire;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_mask;
    logic              wr_hit;
    logic              rd_hit;
    logic [31:0]       rd_word;

    logic              wd_clk_q;
    logic              tick;
    logic [CNT_W-1:0]  wd_count;
    logic [CNT_W-1:0]  count_last;
    logic [18:0]       interval;
    logic              timeout;
    logic              grace_end;
    logic [10:0]       grace_cnt;
    logic [5:0]        hold_cnt;
    wrwt_state_e       state;

    logic              wd_enable;
    logic              wd_irq_enable;
    logic              wd_wake_enable;
    logic              wd_reset_enable;
    logic [2:0]        wd_interval_select;
    logic              wd_counter_clear;
    logic              wd_irq_flag;
    logic              wd_reset_flag;
    logic              wd_wake_flag;
    logic [EV_W-1:0]   ev_status;
    logic [EV_W-1:0]   ev_mask;
    logic [EV_W-1:0]   ev_set;
    logic [1:0]        unlock_stage;
    logic              unlocked;
    logic              do_reset;
    logic              do_wake;

    // Bus slave: address and data are taken in either order, then answered together
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_ctrl = wr_fire && ({aw_addr[ADDR_W-1:2], 2'h0} == OFS_CTRL);
    assign wr_stat = wr_fire && ({aw_addr[ADDR_W-1:2], 2'h0} == OFS_STAT);
    assign wr_mask = wr_fire && ({aw_addr[ADDR_W-1:2], 2'h0} == OFS_MASK);
    assign wr_hit  = wr_ctrl || wr_stat || wr_mask;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Flags live in the bus domain, so a read always shows the latest update
    assign rd_hit = ({s_axi_araddr[ADDR_W-1:2], 2'h0} == OFS_CTRL)
                 || ({s_axi_araddr[ADDR_W-1:2], 2'h0} == OFS_STAT)
                 || ({s_axi_araddr[ADDR_W-1:2], 2'h0} == OFS_MASK);

    always_comb
    begin
        rd_word = '0;
        unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
            OFS_CTRL: rd_word = {21'h0, wd_interval_select, wd_enable, wd_irq_enable, wd_wake_flag,
                                 wd_wake_enable, wd_irq_flag, wd_reset_flag, wd_reset_enable,
                                 wd_counter_clear};
            OFS_STAT: rd_word = {29'h0, ev_status};
            OFS_MASK: rd_word = {29'h0, ev_mask};
            default:  rd_word = '0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Unlock tracker; any further byte while open closes the protection again
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            unlock_stage <= 2'h0;
            unlocked     <= 1'b0;
        end
        else if (register_unlock_port_wr)
        begin
            if (unlocked)
            begin
                unlocked     <= 1'b0;
                unlock_stage <= 2'h0;
            end
            else if (unlock_stage == 2'h0)
            begin
                unlock_stage <= (register_unlock_port_data == UNLOCK_B0) ? 2'h1 : 2'h0;
            end
            else if (unlock_stage == 2'h1)
            begin
                unlock_stage <= (register_unlock_port_data == UNLOCK_B1) ? 2'h2 : 2'h0;
            end
            else
            begin
                unlocked     <= (register_unlock_port_data == UNLOCK_B2);
                unlock_stage <= 2'h0;
            end
        end
    end

    // Protected control fields
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wd_enable          <= CTRL_RESET[BIT_EN];
            wd_irq_enable      <= CTRL_RESET[BIT_IRQ_EN];
            wd_wake_enable     <= CTRL_RESET[BIT_WAKE_EN];
            wd_reset_enable    <= CTRL_RESET[BIT_RST_EN];
            wd_interval_select <= CTRL_RESET[SEL_MSB:SEL_LSB];
            wd_counter_clear   <= CTRL_RESET[BIT_CLR];
        end
        else
        begin
            if (wd_counter_clear)
            begin
                wd_counter_clear <= 1'b0;
            end
            if (wr_ctrl && unlocked && w_strb[0])
            begin
                wd_enable       <= w_data[BIT_EN];
                wd_irq_enable   <= w_data[BIT_IRQ_EN];
                wd_wake_enable  <= w_data[BIT_WAKE_EN];
                wd_reset_enable <= w_data[BIT_RST_EN];
                if (w_data[BIT_CLR])
                begin
                    wd_counter_clear <= 1'b1;
                end
            end
            if (wr_ctrl && unlocked && w_strb[1])
            begin
                wd_interval_select <= w_data[SEL_MSB:SEL_LSB];
            end
        end
    end

    // Watchdog clock is sampled; its rising edge steps all watchdog timing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wd_clk_q <= 1'b0;
        end
        else
        begin
            wd_clk_q <= watchdog_clock;
        end
    end

    assign tick       = watchdog_clock && !wd_clk_q;
    assign interval   = 19'h1 << (SHIFT_BASE + {1'b0, wd_interval_select, 1'b0});
    assign count_last = CNT_W'(interval - 19'h1);
    assign timeout    = (state == WRWT_COUNT) && tick && (wd_count == count_last);
    assign grace_end  = (state == WRWT_GRACE) && tick && (grace_cnt == GRACE_LAST);
    assign do_reset   = grace_end && wd_reset_enable;
    assign do_wake    = grace_end && power_down && wd_wake_enable && low_speed_rc_clock_sel;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !wd_enable || wd_counter_clear)
        begin
            wd_count <= '0;
        end
        else if (tick && state != WRWT_HOLD)
        begin
            wd_count <= wd_count + 1'b1;
        end
    end

    // Sequence: count, grace after time-out, then optional reset hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state       <= WRWT_IDLE;
            grace_cnt   <= '0;
            hold_cnt    <= '0;
            cpu_reset   <= 1'b0;
            chip_wakeup <= 1'b0;
        end
        else
        begin
            chip_wakeup <= do_wake;
            unique case (state)
                WRWT_IDLE:
                begin
                    if (wd_enable)
                    begin
                        state <= WRWT_COUNT;
                    end
                end
                WRWT_COUNT:
                begin
                    grace_cnt <= '0;
                    if (!wd_enable)
                    begin
                        state <= WRWT_IDLE;
                    end
                    else if (timeout)
                    begin
                        state <= WRWT_GRACE;
                    end
                end
                WRWT_GRACE:
                begin
                    if (!wd_enable)
                    begin
                        state <= WRWT_IDLE;
                    end
                    else if (wd_counter_clear)
                    begin
                        state <= WRWT_COUNT;
                    end
                    else if (do_reset)
                    begin
                        state     <= WRWT_HOLD;
                        cpu_reset <= 1'b1;
                        hold_cnt  <= '0;
                    end
                    else if (grace_end)
                    begin
                        state <= WRWT_COUNT;
                    end
                    else if (tick)
                    begin
                        grace_cnt <= grace_cnt + 1'b1;
                    end
                end
                WRWT_HOLD:
                begin
                    // A started reset always runs its full length, even if disabled meanwhile
                    if (tick && hold_cnt == HOLD_LAST)
                    begin
                        state     <= wd_enable ? WRWT_COUNT : WRWT_IDLE;
                        cpu_reset <= 1'b0;
                    end
                    else if (tick)
                    begin
                        hold_cnt <= hold_cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // Sticky flags: a set in the same cycle as a write-one clear wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wd_irq_flag   <= CTRL_RESET[BIT_IRQ_FLAG];
            wd_reset_flag <= CTRL_RESET[BIT_RST_FLAG];
            wd_wake_flag  <= CTRL_RESET[BIT_WAKE_FLAG];
        end
        else
        begin
            wd_irq_flag   <= timeout  || (wd_irq_flag && !(wr_ctrl && w_strb[0] && w_data[BIT_IRQ_FLAG]));
            wd_reset_flag <= do_reset || (wd_reset_flag && !(wr_ctrl && w_strb[0] && w_data[BIT_RST_FLAG]));
            wd_wake_flag  <= do_wake  || (wd_wake_flag && !(wr_ctrl && w_strb[0] && w_data[BIT_WAKE_FLAG]));
        end
    end

    assign ev_set = {do_wake, do_reset, timeout};

    generate
        for (genvar i = 0; i < EV_W; i++)
        begin : g_event
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    ev_status[i] <= 1'b0;
                    ev_mask[i]   <= 1'b0;
                end
                else
                begin
                    ev_status[i] <= ev_set[i] || (ev_status[i] && !(wr_stat && w_strb[0] && w_data[i]));
                    if (wr_mask && w_strb[0])
                    begin
                        ev_mask[i] <= w_data[i];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= (wd_irq_flag && wd_irq_enable) || |(ev_status & ev_mask);
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_count_step;
        tick && state == WRWT_COUNT && wd_enable && !wd_counter_clear |=> wd_count == CNT_W'($past(wd_count) + 1'b1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step on tick");

    property p_timeout_flag;
        state == WRWT_COUNT && tick && wd_count == count_last |=> wd_irq_flag && state != WRWT_COUNT;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("time-out did not set flag");

    property p_grace_len;
        $rose(cpu_reset) |-> $past(grace_cnt) == GRACE_LAST && $past(state) == WRWT_GRACE;
    endproperty
    a_grace_len: assert property (p_grace_len) else $error("reset before grace end");

    property p_hold_len;
        $fell(cpu_reset) |-> $past(hold_cnt) == HOLD_LAST;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset hold length wrong");

    property p_reset_needs_enable;
        $rose(cpu_reset) |-> $past(wd_reset_enable) && wd_reset_flag;
    endproperty
    a_reset_needs_enable: assert property (p_reset_needs_enable) else $error("reset without enable");

    property p_flag_keeps;
        $rose(wd_reset_flag) |-> $past(wd_reset_enable);
    endproperty
    a_flag_keeps: assert property (p_flag_keeps) else $error("reset flag set while disabled");

    property p_clear_action;
        wd_counter_clear && !wr_ctrl |=> wd_count == '0 && !wd_counter_clear;
    endproperty
    a_clear_action: assert property (p_clear_action) else $error("clear did not act");

    property p_disable_stop;
        !wd_enable && state != WRWT_HOLD |=> state == WRWT_IDLE && wd_count == '0;
    endproperty
    a_disable_stop: assert property (p_disable_stop) else $error("disable did not stop");

    property p_locked;
        wr_ctrl && !unlocked |=> $stable(wd_enable) && $stable(wd_interval_select) && $stable(wd_reset_enable);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write took effect");

    property p_wake_src;
        chip_wakeup |-> wd_wake_flag && $past(low_speed_rc_clock_sel) && $past(power_down);
    endproperty
    a_wake_src: assert property (p_wake_src) else $error("wakeup from wrong source");

    c_timeout: cover property (timeout);
    c_reset:   cover property ($fell(cpu_reset));
    c_wake:    cover property (chip_wakeup);
    c_rescue:  cover property (state == WRWT_GRACE ##1 wd_counter_clear ##1 state == WRWT_COUNT);
endmodule

// ### dv/tb_wrwt_watchdog.sv
// Self-checking bench for the watchdog: registers over AXI4-Lite, unlock port and system outputs.
// Assumes the design's own assertions watch the ports; this bench only drives and compares.
`timescale 1ns/1ps
module tb_wrwt_watchdog;
    import wrwt_pkg::*;
    logic aclk = 0, aresetn = 0, wdclk = 0, rc_sel = 0, pdown = 0, ul_wr = 0;
    logic [7:0] ul_data = 8'h00;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, cpu_reset, chip_wakeup;
    logic [31:0] wdata = '0, rdata, rd;
    logic [1:0] bresp, rresp, rsp;
    logic [3:0] wstrb = 4'hF;
    logic wd_prev = 0;
    int bad_count = 0, checks = 0, n, ticks;

    wrwt_watchdog wrwt_watchdog_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .watchdog_clock(wdclk), .low_speed_rc_clock_sel(rc_sel), .power_down(pdown),
        .register_unlock_port_wr(ul_wr), .register_unlock_port_data(ul_data),
        .irq(irq), .cpu_reset(cpu_reset), .chip_wakeup(chip_wakeup));

    initial forever #4 aclk = ~aclk;
    // Watchdog clock at a quarter of the bus rate, offset so its edges never meet aclk
    initial begin #3; forever #16 wdclk = ~wdclk; end
    always @(posedge aclk) wd_prev <= wdclk;

    task automatic end_sim();
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t;
        aw_t = 0;
        w_t = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(aw_t && w_t))
        begin
            @(posedge aclk);
            if (awvalid && awready) begin aw_t = 1; awvalid <= 0; end
            if (wvalid && wready) begin w_t = 1; wvalid <= 0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask

    task automatic rdw(logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask

    task automatic rchk(string name, logic [11:0] a, logic [31:0] exp);
        rdw(a, rd, rsp);
        chk(name, rd, exp);
    endtask

    task automatic unlock();
        ul_wr <= 1; ul_data <= UNLOCK_B0; @(posedge aclk);
        ul_data <= UNLOCK_B1; @(posedge aclk);
        ul_data <= UNLOCK_B2; @(posedge aclk);
        ul_wr <= 0; @(posedge aclk);
    endtask

    // Bounded wait on a design output, in bus cycles
    task automatic wait_hi(ref logic s, input int lim);
        for (n = 0; n < lim && s !== 1'b1; n++) @(posedge aclk);
    endtask

    initial begin
        #400000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rchk("ctrl_rst", OFS_CTRL, CTRL_RESET);
        rchk("stat_rst", OFS_STAT, 32'h0);
        rchk("mask_rst", OFS_MASK, 32'h0);
        rdw(12'h00C, rd, rsp); chk("rd_unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(12'h010, 32'hFF, rsp); chk("wr_unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(OFS_CTRL, 32'h0000_00C2, rsp);
        rchk("ctrl_locked", OFS_CTRL, CTRL_RESET);
        unlock();
        for (int s = 0; s < 8; s++)
        begin
            wr(OFS_CTRL, 32'(s) << SEL_LSB, rsp);
            rchk("sel_code", OFS_CTRL, 32'(s) << SEL_LSB);
        end
        // Time-out then uncleared grace ends in a CPU reset
        wr(OFS_CTRL, 32'h0000_00C2, rsp);
        wait_hi(irq, 200); chk("irq_timeout", {31'h0, irq}, 32'h1);
        chk("interval_0", {31'h0, n >= 56 && n <= 72}, 32'h1);
        chk("no_early_reset", {31'h0, cpu_reset}, 32'h0);
        // A zero in the clear field must neither rescue the CPU nor drop the pending flag
        wr(OFS_CTRL, 32'h0000_00C2, rsp);
        chk("irq_w0", {31'h0, irq}, 32'h1);
        wait_hi(cpu_reset, 4400); chk("reset_rise", {31'h0, cpu_reset}, 32'h1);
        ticks = 0;
        for (n = 0; n < 400 && cpu_reset === 1'b1; n++)
        begin
            @(posedge aclk);
            if (wdclk && !wd_prev) ticks++;
        end
        chk("reset_ticks", 32'(ticks), 32'd63);
        rchk("ctrl_flags", OFS_CTRL, 32'h0000_00CE);
        rchk("stat_ev", OFS_STAT, 32'h3);
        wr(OFS_CTRL, 32'h0000_000C, rsp);
        rchk("ctrl_w1c", OFS_CTRL, 32'h0);
        chk("irq_off", {31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h1, rsp);
        chk("irq_mask", {31'h0, irq}, 32'h1);
        wr(OFS_STAT, 32'h3, rsp);
        rchk("stat_clr", OFS_STAT, 32'h0);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        // Clearing the counter inside the grace delay averts the reset; interval code 1 here
        wr(OFS_CTRL, 32'h0000_01C2, rsp);
        wait_hi(irq, 300);
        chk("interval_1", {31'h0, n >= 248 && n <= 264}, 32'h1);
        wr(OFS_CTRL, 32'h0000_01CB, rsp);
        rchk("clr_self", OFS_CTRL, 32'h0000_01C2);
        for (n = 0; n < 4100; n++)
        begin
            @(posedge aclk);
            if (cpu_reset !== 1'b0) break;
        end
        chk("no_reset_after_clr", 32'(n), 32'd4100);
        wr(OFS_CTRL, 32'h0000_000C, rsp);
        wr(OFS_STAT, 32'h7, rsp);
        // Powered down, reset disabled: wakeup only while the low-speed source is selected
        pdown <= 1;
        for (int r = 0; r < 2; r++)
        begin
            rc_sel <= r[0];
            wr(OFS_CTRL, 32'h0000_00D0, rsp);
            for (n = 0; n < 4600 && chip_wakeup !== 1'b1; n++)
            begin
                @(posedge aclk);
                if (cpu_reset !== 1'b0) chk("reset_disabled", {31'h0, cpu_reset}, 32'h0);
            end
            chk("wakeup", {31'h0, chip_wakeup}, 32'(r));
            // Disable to restart the count from zero for the second pass
            if (r == 0) wr(OFS_CTRL, 32'h0000_0008, rsp);
        end
        rchk("ctrl_wake", OFS_CTRL, 32'h0000_00F8);
        rchk("stat_wake", OFS_STAT, 32'h5);
        wr(OFS_CTRL, 32'h0000_0028, rsp);
        rchk("wake_w1c", OFS_CTRL, 32'h0);
        end_sim();
    end
endmodule
